// ===== rtl/tcu_pkg.sv
package tcu_pkg;
	localparam logic [7:0] TCU_OFS_MODE = 8'h00;
	localparam logic [7:0] TCU_OFS_IOCTL = 8'h04;
	localparam logic [7:0] TCU_OFS_INTEN = 8'h08;
	localparam logic [7:0] TCU_OFS_STATUS = 8'h0C;
	localparam logic [7:0] TCU_OFS_COUNT = 8'h10;
	localparam logic [7:0] TCU_OFS_GR_FIRST = 8'h14;
	localparam logic [7:0] TCU_OFS_GR_SECOND = 8'h18;
	localparam int TCU_BIT_A = 0;
	localparam int TCU_BIT_B = 1;
	localparam int TCU_BIT_V = 2;
	localparam int TCU_BIT_U = 3;
	localparam int TCU_MODE_TOP = 3;
	localparam logic [3:0] TCU_MODE_RST = 4'h0;
	localparam logic [7:0] TCU_IOCTL_RST = 8'h00;
	localparam logic [3:0] TCU_INTEN_RST = 4'h0;
	localparam logic [15:0] TCU_COUNT_RST = 16'h0000;
	localparam logic [15:0] TCU_GR_RST = 16'hFFFF;
	localparam logic [15:0] TCU_COUNT_MAX = 16'hFFFF;
	localparam logic [15:0] TCU_COUNT_MIN = 16'h0000;
	typedef enum logic [2:0] {
		TCU_NORMAL,
		TCU_RESERVED,
		TCU_PWM1,
		TCU_PWM2,
		TCU_PHASE1,
		TCU_PHASE2,
		TCU_PHASE3,
		TCU_PHASE4
	} tcu_mode_e;
endpackage

// ===== rtl/tcu_gr_unit.sv
`timescale 1ns/100ps
module tcu_gr_unit
	import tcu_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	input wire logic [3:0] io,
	input wire logic pin_sync,
	input wire logic casc_event,
	input wire logic [15:0] counter,
	input wire logic cnt_moved,
	input wire logic wr_en,
	input wire logic [15:0] wr_data,
	output logic [15:0] value,
	output logic event_hit,
	output logic pin_out,
	output logic pin_oe
);
	logic pin_q;
	logic [3:0] io_q;
	logic oc_mode;
	logic rise;
	logic fall;
	logic match;
	logic cap_hit;

	assign oc_mode = !io[3];
	assign rise = pin_sync && !pin_q;
	assign fall = !pin_sync && pin_q;
	assign match = oc_mode && cnt_moved && (counter == value);
	// Pin capture picks its edge, cascade capture ignores the pin.
	assign cap_hit = (io[3:2] == 2'h2 && (io[1] ? (rise || fall) : (io[0] ? fall : rise)))
		|| (io[3:2] == 2'h3 && casc_event);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_q <= 1'h0;
			io_q <= TCU_IOCTL_RST[3:0];
		end else if (ce) begin
			pin_q <= pin_sync;
			io_q <= io;
		end
	end

	// A software write wins over a capture in the same cycle.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			value <= TCU_GR_RST;
			event_hit <= 1'h0;
		end else if (ce) begin
			if (wr_en) begin
				value <= wr_data;
			end else if (cap_hit) begin
				value <= counter;
			end
			event_hit <= match || cap_hit;
		end
	end

	// A change of the control field reloads the initial level.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_out <= 1'h0;
			pin_oe <= 1'h0;
		end else if (ce) begin
			pin_oe <= oc_mode && (io[1:0] != 2'h0);
			if (io != io_q) begin
				pin_out <= io[2];
			end else if (match) begin
				unique case (io[1:0])
					2'h1: pin_out <= 1'h0;
					2'h2: pin_out <= 1'h1;
					2'h3: pin_out <= !pin_out;
					2'h0: pin_out <= pin_out;
				endcase
			end
		end
	end

	a_pin_capture: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && !wr_en && io[3:2] == 2'h2 && io[1:0] == 2'h0 && rise) |=> value == $past(counter))
		else $error("rising pin edge did not capture the counter");
	a_casc_capture: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && !wr_en && io[3:2] == 2'h3 && casc_event) |=> (value == $past(counter) && event_hit))
		else $error("cascade event did not capture the counter");
	a_match_action: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && match && io == io_q && io[1:0] == 2'h1) |=> !pin_out)
		else $error("compare match did not drive the pin low");
	a_initial_level: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && io != io_q && oc_mode) |=> pin_out == $past(io[2]))
		else $error("initial pin level not loaded");
	a_output_disable: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && (io[3] || io[1:0] == 2'h0)) |=> !pin_oe)
		else $error("pin driven while output disabled");
endmodule

// ===== rtl/tcu_chan.sv
// How it works
// - Mode bits 000 normal, 001 reserved, 010/011 PWM 1/2, 100-111 phase counting 1-4.
// - Control top bit 0 means output compare; low bits 00 disable the pin.
// - In compare mode the second-highest bit gives the pin's initial level.
// - Compare match action: 01 drives low, 10 drives high, 11 toggles.
// - Codes 10xx capture the counter on pin rising, falling or both edges.
// - First register codes 11xx capture on neighbour's first register event.
// - Second register codes 11xx capture on neighbour's third register event.
// - Match A interrupt follows the A flag only while its enable is set.
// - Match B interrupt follows the B flag only while its enable is set.
// - Overflow flag sets on wrap from maximum to zero; cleared by zero after one.
// - Underflow flag sets on wrap from zero to maximum; cleared by zero after one.
// - A flag sets on compare equality or on capture into register A.
//
// The placing of the registers and register access over AHB-Lite were left to the implementer.
`timescale 1ns/100ps
module tcu_chan
	import tcu_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic count_tick,
	input wire logic count_down,
	input wire logic channel_pin_a_in,
	input wire logic channel_pin_b_in,
	input wire logic nb_first_event,
	input wire logic nb_third_event,
	output logic channel_pin_a_out,
	output logic channel_pin_a_oe,
	output logic channel_pin_b_out,
	output logic channel_pin_b_oe,
	output tcu_mode_e op_mode,
	output logic match_a_irq,
	output logic match_b_irq,
	output logic overflow_irq,
	output logic underflow_irq
);
	logic ap_valid;
	logic ap_write;
	logic [7:0] ap_addr;
	logic wr_stb;
	logic rd_status;
	logic [31:0] rd_mux;
	logic [3:0] mode_reg;
	logic [7:0] ioctl;
	logic [3:0] inten;
	logic [3:0] flag;
	logic [3:0] armed;
	logic [3:0] clear_req;
	logic [3:0] events;
	logic [15:0] counter;
	logic cnt_moved;
	logic step;
	logic down;
	logic ovf_ev;
	logic udf_ev;
	logic [1:0] pin_s1;
	logic [1:0] pin_s2;
	logic [1:0] pin_raw;
	logic [1:0] casc;
	logic [15:0] gr_val [2];
	logic [1:0] gr_ev;
	logic [1:0] gr_wr;
	logic [1:0] pin_o;
	logic [1:0] pin_e;
	tcu_mode_e next_op_mode;

	// Every access takes one wait state so that read data come from a flop.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_valid <= 1'h0;
			ap_write <= 1'h0;
			ap_addr <= 8'h00;
			hreadyout <= 1'h1;
			hresp <= 1'h0;
			hrdata <= 32'h00000000;
		end else if (ce) begin
			if (hready && hsel && htrans[1]) begin
				ap_valid <= 1'h1;
				ap_write <= hwrite;
				ap_addr <= haddr[7:0];
				hreadyout <= 1'h0;
			end else if (ap_valid) begin
				ap_valid <= 1'h0;
				hreadyout <= 1'h1;
				hrdata <= ap_write ? 32'h00000000 : rd_mux;
			end
		end
	end

	assign wr_stb = ap_valid && ap_write;
	assign rd_status = ap_valid && !ap_write && ap_addr == TCU_OFS_STATUS;

	always_comb begin
		rd_mux = 32'h00000000;
		unique case (ap_addr)
			TCU_OFS_MODE: rd_mux[3:0] = mode_reg;
			TCU_OFS_IOCTL: rd_mux[7:0] = ioctl;
			TCU_OFS_INTEN: rd_mux[3:0] = inten;
			TCU_OFS_STATUS: rd_mux[3:0] = flag;
			TCU_OFS_COUNT: rd_mux[15:0] = counter;
			TCU_OFS_GR_FIRST: rd_mux[15:0] = gr_val[0];
			TCU_OFS_GR_SECOND: rd_mux[15:0] = gr_val[1];
			default: rd_mux = 32'h00000000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode_reg <= TCU_MODE_RST;
			ioctl <= TCU_IOCTL_RST;
			inten <= TCU_INTEN_RST;
		end else if (ce && wr_stb) begin
			if (ap_addr == TCU_OFS_MODE) begin
				mode_reg <= hwdata[3:0];
			end
			if (ap_addr == TCU_OFS_IOCTL) begin
				ioctl <= hwdata[7:0];
			end
			if (ap_addr == TCU_OFS_INTEN) begin
				inten <= hwdata[3:0];
			end
		end
	end

	// A set top bit gives an undefined mode, treated as reserved: the counter holds.
	always_comb begin
		if (mode_reg[TCU_MODE_TOP]) begin
			next_op_mode = TCU_RESERVED;
		end else begin
			next_op_mode = tcu_mode_e'(mode_reg[2:0]);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			op_mode <= TCU_NORMAL;
		end else if (ce) begin
			op_mode <= next_op_mode;
		end
	end

	assign step = count_tick && op_mode != TCU_RESERVED;
	assign down = count_down && (op_mode == TCU_PHASE1 || op_mode == TCU_PHASE2
		|| op_mode == TCU_PHASE3 || op_mode == TCU_PHASE4);
	assign ovf_ev = step && !down && counter == TCU_COUNT_MAX;
	assign udf_ev = step && down && counter == TCU_COUNT_MIN;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			counter <= TCU_COUNT_RST;
			cnt_moved <= 1'h0;
		end else if (ce) begin
			cnt_moved <= step;
			if (wr_stb && ap_addr == TCU_OFS_COUNT) begin
				counter <= hwdata[15:0];
			end else if (step) begin
				counter <= down ? counter - 16'h0001 : counter + 16'h0001;
			end
		end
	end

	// The clear needs a prior read of one; a new event in the clear cycle wins.
	assign events = {udf_ev, ovf_ev, gr_ev[1], gr_ev[0]};
	assign clear_req = (wr_stb && ap_addr == TCU_OFS_STATUS) ? (~hwdata[3:0] & armed) : 4'h0;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flag <= 4'h0;
			armed <= 4'h0;
		end else if (ce) begin
			flag <= events | (flag & ~clear_req);
			armed <= (armed & ~clear_req & flag) | (rd_status ? flag : 4'h0);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			match_a_irq <= 1'h0;
			match_b_irq <= 1'h0;
			overflow_irq <= 1'h0;
			underflow_irq <= 1'h0;
		end else if (ce) begin
			match_a_irq <= flag[TCU_BIT_A] && inten[TCU_BIT_A];
			match_b_irq <= flag[TCU_BIT_B] && inten[TCU_BIT_B];
			overflow_irq <= flag[TCU_BIT_V] && inten[TCU_BIT_V];
			underflow_irq <= flag[TCU_BIT_U] && inten[TCU_BIT_U];
		end
	end

	assign pin_raw = {channel_pin_b_in, channel_pin_a_in};
	assign casc = {nb_third_event, nb_first_event};
	assign gr_wr[0] = wr_stb && ap_addr == TCU_OFS_GR_FIRST;
	assign gr_wr[1] = wr_stb && ap_addr == TCU_OFS_GR_SECOND;

	// Pins are asynchronous; the first stage feeds only the second.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_s1 <= 2'h0;
			pin_s2 <= 2'h0;
		end else if (ce) begin
			pin_s1 <= pin_raw;
			pin_s2 <= pin_s1;
		end
	end

	for (genvar g = 0; g < 2; g++) begin : g_unit
		tcu_gr_unit u_unit (
			.hclk(hclk),
			.hresetn(hresetn),
			.ce(ce),
			.io(ioctl[g*4 +: 4]),
			.pin_sync(pin_s2[g]),
			.casc_event(casc[g]),
			.counter(counter),
			.cnt_moved(cnt_moved),
			.wr_en(gr_wr[g]),
			.wr_data(hwdata[15:0]),
			.value(gr_val[g]),
			.event_hit(gr_ev[g]),
			.pin_out(pin_o[g]),
			.pin_oe(pin_e[g])
		);
	end

	assign channel_pin_a_out = pin_o[0];
	assign channel_pin_a_oe = pin_e[0];
	assign channel_pin_b_out = pin_o[1];
	assign channel_pin_b_oe = pin_e[1];

	a_mode_decode: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && mode_reg == 4'h2) |=> op_mode == TCU_PWM1)
		else $error("mode 010 not decoded as PWM mode 1");
	a_mode_top_bit: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && mode_reg[TCU_MODE_TOP]) |=> op_mode == TCU_RESERVED)
		else $error("top mode bit did not stop the mode");
	a_irq_a_gate: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && $rose(flag[TCU_BIT_A])) |-> ##1 (match_a_irq == $past(inten[TCU_BIT_A])))
		else $error("match A request does not follow flag and enable");
	a_irq_b_gate: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && !inten[TCU_BIT_B]) |=> !match_b_irq)
		else $error("match B request while disabled");
	a_irq_ovf_gate: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && flag[TCU_BIT_V] && inten[TCU_BIT_V]) |=> overflow_irq)
		else $error("overflow request missing");
	a_ovf_flag_set: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && ovf_ev && !(wr_stb && ap_addr == TCU_OFS_COUNT)) |=>
		(flag[TCU_BIT_V] && counter == TCU_COUNT_MIN))
		else $error("overflow wrap did not set the flag");
	a_udf_flag_set: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && udf_ev) |=> flag[TCU_BIT_U])
		else $error("underflow wrap did not set the flag");
	a_flag_a_set: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && gr_ev[0]) |=> flag[TCU_BIT_A] ##1 (flag[TCU_BIT_A] || !ce || $past(clear_req[0])))
		else $error("match A event did not set the flag");
	a_clear_needs_read: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && flag[TCU_BIT_V] && !armed[TCU_BIT_V] && !rd_status) |=> flag[TCU_BIT_V])
		else $error("flag cleared without a prior read");
	// Requests sit one flop behind flag and enable, so each check looks one cycle on.
	a_irq_a_on: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && flag[TCU_BIT_A] && inten[TCU_BIT_A]) |=> match_a_irq)
		else $error("match A request missing");
	a_irq_a_off: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && !inten[TCU_BIT_A]) |=> !match_a_irq)
		else $error("match A request while disabled");
	a_irq_b_on: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && flag[TCU_BIT_B] && inten[TCU_BIT_B]) |=> match_b_irq)
		else $error("match B request missing");
	a_irq_ovf_off: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && !inten[TCU_BIT_V]) |=> !overflow_irq)
		else $error("overflow request while disabled");
	a_irq_udf_gate: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && flag[TCU_BIT_U] && inten[TCU_BIT_U]) |=> underflow_irq)
		else $error("underflow request missing");
	a_udf_wrap: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && udf_ev && !(wr_stb && ap_addr == TCU_OFS_COUNT)) |=>
		(flag[TCU_BIT_U] && counter == TCU_COUNT_MAX))
		else $error("underflow wrap did not reach the maximum");
	a_ovf_flag_clear: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && wr_stb && ap_addr == TCU_OFS_STATUS && armed[TCU_BIT_V]
		&& !hwdata[TCU_BIT_V] && !ovf_ev) |=> !flag[TCU_BIT_V])
		else $error("armed overflow flag not cleared by a zero write");
	a_mode_phase: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && mode_reg == 4'h4) |=> op_mode == TCU_PHASE1)
		else $error("mode 100 not decoded as phase counting mode 1");
	a_reserved_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && op_mode == TCU_RESERVED && !(wr_stb && ap_addr == TCU_OFS_COUNT)) |=>
		$stable(counter))
		else $error("counter moved in the reserved mode");

	c_ovf_irq: cover property (@(posedge hclk) disable iff (!hresetn) overflow_irq);
	c_udf_irq: cover property (@(posedge hclk) disable iff (!hresetn) underflow_irq);
	c_flag_clear: cover property (@(posedge hclk) disable iff (!hresetn)
		flag[TCU_BIT_A] ##1 !flag[TCU_BIT_A]);
	c_pin_capture: cover property (@(posedge hclk) disable iff (!hresetn)
		gr_ev[1] && ioctl[7:6] == 2'h2);
	c_toggle: cover property (@(posedge hclk) disable iff (!hresetn)
		channel_pin_a_oe && $changed(channel_pin_a_out));
endmodule

// ===== bench/tcu_pin_model.sv
`timescale 1ns/100ps
// The far-side source only reaches the line while the design leaves it undriven.
module tcu_pin_model (
	input wire logic a_out,
	input wire logic a_oe,
	input wire logic b_out,
	input wire logic b_oe,
	input wire logic a_drv,
	input wire logic b_drv,
	output logic a_in,
	output logic b_in
);
	assign a_in = a_oe ? a_out : a_drv;
	assign b_in = b_oe ? b_out : b_drv;
endmodule

// ===== bench/tcu_chan_bench.sv
`timescale 1ns/100ps
module tcu_chan_bench
	import tcu_pkg::*;
;
	logic hclk, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, count_tick = 1'b0, count_down = 1'b0;
	logic nb_first = 1'b0, nb_third = 1'b0, a_drv = 1'b0, b_drv = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rv;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic hreadyout, hresp, a_in, b_in, a_out, a_oe, b_out, b_oe, ia, ib, iv, iu;
	logic [3:0] code;
	logic [3:0] codes [5] = '{4'h5, 4'h2, 4'h3, 4'h7, 4'h4};
	tcu_mode_e op_mode;
	int err_count = 0, n_compared = 0;
	tcu_chan i_dut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .count_tick(count_tick),
		.count_down(count_down), .channel_pin_a_in(a_in), .channel_pin_b_in(b_in),
		.nb_first_event(nb_first), .nb_third_event(nb_third), .channel_pin_a_out(a_out),
		.channel_pin_a_oe(a_oe), .channel_pin_b_out(b_out), .channel_pin_b_oe(b_oe),
		.op_mode(op_mode), .match_a_irq(ia), .match_b_irq(ib), .overflow_irq(iv),
		.underflow_irq(iu));
	tcu_pin_model i_pins (.a_out(a_out), .a_oe(a_oe), .b_out(b_out), .b_oe(b_oe),
		.a_drv(a_drv), .b_drv(b_drv), .a_in(a_in), .b_in(b_in));
	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end
	task complete_run;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t word %h expected %h", $time, got, exp);
		end
	endtask
	task chkb(input logic got, input logic exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t bit %b expected %b", $time, got, exp);
		end
	endtask
	// Address phase is held until ready is seen; data phase likewise, data taken there.
	task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rv = hrdata;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task rd_chk(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(rv, exp);
	endtask
	// Flags only clear on a zero write that follows a read showing them set.
	task clr;
		bus(1'b0, TCU_OFS_STATUS, 32'h0);
		wr(TCU_OFS_STATUS, 32'h0);
	endtask
	task tick;
		@(posedge hclk) count_tick <= 1'b1;
		@(posedge hclk) count_tick <= 1'b0;
	endtask
	initial begin
		#1000000;
		err_count++;
		complete_run;
	end
	initial begin
		repeat (12) @(posedge hclk);
		chk({25'h0, hresp, a_oe, b_oe, ia, ib, iv, iu}, 32'h0);
		hresetn <= 1'b1;
		for (int k = 0; k < 8; k++) begin
			rd_chk(8'(k * 4), (k == 5 || k == 6) ? 32'h0000FFFF : 32'h0);
		end
		$display("test reset done");
		for (int k = 0; k < 8; k++) begin
			wr(TCU_OFS_MODE, 32'(k));
			repeat (2) @(posedge hclk);
			chk({29'h0, op_mode}, 32'(k));
		end
		wr(TCU_OFS_MODE, 32'h0);
		$display("test mode done");
		wr(TCU_OFS_COUNT, 32'h0000FFFF);
		tick;
		repeat (3) @(posedge hclk);
		chkb(iv, 1'b0);
		rd_chk(TCU_OFS_COUNT, 32'h0);
		rd_chk(TCU_OFS_STATUS, 32'h4);
		wr(TCU_OFS_INTEN, 32'h4);
		repeat (2) @(posedge hclk);
		chkb(iv, 1'b1);
		wr(TCU_OFS_STATUS, 32'h0);
		repeat (2) @(posedge hclk);
		chkb(iv, 1'b0);
		wr(TCU_OFS_MODE, 32'h4);
		@(posedge hclk) count_down <= 1'b1;
		wr(TCU_OFS_INTEN, 32'h8);
		tick;
		repeat (3) @(posedge hclk);
		chkb(iu, 1'b1);
		rd_chk(TCU_OFS_COUNT, 32'h0000FFFF);
		// Both general registers still hold the maximum, so the wrap also matches them.
		rd_chk(TCU_OFS_STATUS, 32'hB);
		clr;
		@(posedge hclk) count_down <= 1'b0;
		wr(TCU_OFS_MODE, 32'h0);
		$display("test wrap done");
		wr(TCU_OFS_INTEN, 32'h1);
		wr(TCU_OFS_GR_FIRST, 32'h5);
		for (int k = 0; k < 5; k++) begin
			code = codes[k];
			wr(TCU_OFS_IOCTL, {24'h0, code, code});
			repeat (2) @(posedge hclk);
			chkb(a_oe, code[1:0] != 2'h0);
			chkb(b_oe, code[1:0] != 2'h0);
			if (code[1:0] != 2'h0) chkb(a_out, code[2]);
			if (code[1:0] != 2'h0) chkb(b_out, code[2]);
			wr(TCU_OFS_COUNT, 32'h3);
			tick;
			tick;
			repeat (4) @(posedge hclk);
			if (code[1:0] != 2'h0) chkb(a_out, code[1:0] == 2'h3 ? ~code[2] : code[1]);
			rd_chk(TCU_OFS_STATUS, 32'h1);
			chkb(ia, 1'b1);
			clr;
		end
		$display("test compare done");
		wr(TCU_OFS_INTEN, 32'h2);
		for (int k = 0; k < 3; k++) begin
			code = 4'h8 + 4'(k);
			wr(TCU_OFS_IOCTL, {24'h0, code, 4'h0});
			wr(TCU_OFS_COUNT, 32'h30 + 32'(k));
			repeat (6) @(posedge hclk);
			clr;
			@(posedge hclk) b_drv <= 1'b1;
			repeat (8) @(posedge hclk);
			chkb(ib, code != 4'h9);
			rd_chk(TCU_OFS_STATUS, code != 4'h9 ? 32'h2 : 32'h0);
			clr;
			@(posedge hclk) b_drv <= 1'b0;
			repeat (8) @(posedge hclk);
			rd_chk(TCU_OFS_STATUS, code != 4'h8 ? 32'h2 : 32'h0);
		end
		rd_chk(TCU_OFS_GR_SECOND, 32'h32);
		$display("test capture done");
		wr(TCU_OFS_IOCTL, 32'hCC);
		wr(TCU_OFS_COUNT, 32'h41);
		@(posedge hclk) nb_first <= 1'b1;
		@(posedge hclk) nb_first <= 1'b0;
		repeat (3) @(posedge hclk);
		rd_chk(TCU_OFS_GR_FIRST, 32'h41);
		wr(TCU_OFS_COUNT, 32'h42);
		@(posedge hclk) nb_third <= 1'b1;
		@(posedge hclk) nb_third <= 1'b0;
		repeat (3) @(posedge hclk);
		rd_chk(TCU_OFS_GR_SECOND, 32'h42);
		rd_chk(TCU_OFS_GR_FIRST, 32'h41);
		$display("test cascade done");
		complete_run;
	end
endmodule
